// file: pkg/spg_cfg.svh
// constants of the serial programming port
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH
`define SPG_CLK_MHZ 25
`define SPG_T_FLASH_US 4500
`define SPG_T_EEP_US 9000
`define SPG_T_ERASE_US 9000
`define SPG_TMR_W 18
`define SPG_OP_MISC 8'hAC
`define SPG_PE_B2 8'h53
`define SPG_ER_TOP 3'b100
`define SPG_LOCK_TOP 3'b111
`define SPG_FUSE_LO 8'hA0
`define SPG_FUSE_HI 8'hA8
`define SPG_H_MASK 8'hF7
`define SPG_H_BIT 3
`define SPG_LOAD_PG 8'h40
`define SPG_WRITE_PG 8'h4C
`define SPG_RD_PROG 8'h20
`define SPG_RD_EEP 8'hA0
`define SPG_WR_EEP 8'hC0
`define SPG_RD_LOCK 8'h58
`define SPG_RD_FUSE 8'h50
`define SPG_RD_FHI_B2 8'h08
`define SPG_ERASED8 8'hFF
`define SPG_ERASED16 16'hFFFF
`define SPG_LOCK_FIX 2'h3
`define SPG_FUSE_RST 8'hFF
`define SPG_FLASH_WORDS 32768
`define SPG_EEP_BYTES 2048
`define SPG_PAGE_WORDS 128
`define SPG_BYTE2_AT 5'h10
`define SPG_BYTE3_AT 5'h18
`define SPG_LAST_BIT 5'h1F
`define SPG_PEN_CAP 3'h5
`define SPG_PIN_IDLE 3'h6
`define SPG_PIN_SCK 0
`define SPG_PIN_RST 1
`define SPG_PIN_PEN 2
`endif

// file: pkg/spg_pkg.sv
// types of the serial programming port
package spg_pkg;
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } spg_instr_t;
   typedef enum logic [1:0] {
      SPG_IDLE = 2'h0,
      SPG_ERASE = 2'h1,
      SPG_PAGE = 2'h2,
      SPG_WAIT = 2'h3
   } spg_state_t;
endpackage : spg_pkg

// file: rtl/spg_prog_port.sv
// serial programming port: link shifter, command engine and memories
`timescale 1ns/1ps
`include "spg_cfg.svh"
// How it works
// R1 - flash and eeprom programmable only while reset pin held low; after pen entry also with reset high
// R2 - nothing but programming-enable is acted on before that instruction
// R3 - serial input is sampled on rising clock edge
// R4 - serial output changes on falling clock edge
// R5 - programmer keeps serial clock low and high several core cycles
// R6 - programmer powers up with reset and clock low, else pulses reset
// R7 - entry pin low with clock low at power-on selects mode
// R8 - programmer waits 20 ms before programming-enable
// R9 - second enable byte echoes while third byte shifts in
// R10 - programmer always sends all four enable bytes
// R11 - missing echo: programmer pulses reset and retries enable
// R12 - page buffer loaded one byte per instruction, 7-bit word address
// R13 - programmer loads low byte before high byte per word
// R14 - write-page with 8-bit page address commits buffer to flash
// R15 - programmer waits page-write time before next page
// R16 - eeprom byte write erases then writes, self-timed
// R17 - programmer waits eeprom write time before next byte
// R18 - chip erase sets all flash and eeprom to FF
// R19 - read instruction shifts addressed content out serially
// R20 - reset pin high ends programming mode; after pen entry the mode holds until resetn
// R21 - programmer issues only reads while a write is pending
// R22 - dedicated serial data pins, only the clock is shared
// R23 - waits are 4.5 ms per page and 9.0 ms per eeprom byte
// R24 - enable is AC, 53, then two don't-care bytes
// R25 - erase is AC, byte two starting 100, rest don't-care
// R26 - bytes go msb first, four bytes make one instruction
module spg_prog_port #(
   parameter int FLASH_WAIT_CYC = `SPG_T_FLASH_US * `SPG_CLK_MHZ,
   parameter int EEP_WAIT_CYC = `SPG_T_EEP_US * `SPG_CLK_MHZ,
   parameter int ERASE_WAIT_CYC = `SPG_T_ERASE_US * `SPG_CLK_MHZ
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic prog_sck,
   input wire logic prog_reset_n,
   input wire logic program_entry_pin_n,
   input wire logic prog_serial_in,
   output logic prog_serial_out,
   output logic prog_serial_out_oe_n,
   output logic prog_mode,
   output logic prog_busy,
   output logic [3:0] clock_source_fuses
);

   ////////////////////////////////////////////////////////////////////
   // storage, written only on core_clk
   logic [15:0] flash_mem [`SPG_FLASH_WORDS];
   logic [7:0] eep_mem [`SPG_EEP_BYTES];
   logic [15:0] pbuf_mem [`SPG_PAGE_WORDS];
   logic [7:0] lock_reg;
   logic [7:0] fuse_lo_reg;
   logic [7:0] fuse_hi_reg;
   logic busy_reg;
   logic pen_mode_reg;
   logic mode_reg;
   logic oe_n_reg;

   ////////////////////////////////////////////////////////////////////
   // link domain on prog_sck
   logic link_rst;
   logic [4:0] bit_cnt_reg;
   logic [31:0] sh_reg;
   spg_pkg::spg_instr_t word_reg;
   logic tog_reg;
   logic enabled_reg;
   logic busy_s1_reg;
   logic busy_s2_reg;
   logic [7:0] out_sh_reg;
   wire [31:0] sh_full;
   wire is_enable;
   wire [7:0] lb1;
   wire [7:0] lb2;
   wire [7:0] lb3;
   wire [14:0] rd_waddr;
   wire [10:0] rd_eaddr;
   wire [15:0] rd_word;
   wire rd_flash;
   wire rd_eep;
   wire rd_lock;
   wire rd_fhi;
   wire rd_flo;
   wire [7:0] rd_mem_byte;
   wire [7:0] rd_byte;

   // pen entry holds until resetn, so the link stays awake with reset high
   assign link_rst = prog_reset_n & ~pen_mode_reg; // R1 R20 R7
   assign sh_full = {sh_reg[30:0], prog_serial_in}; // R26
   assign is_enable = sh_full[31:24] == `SPG_OP_MISC
      && sh_full[23:16] == `SPG_PE_B2; // R24

   always_ff @(posedge prog_sck or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_reg <= 5'h00;
         sh_reg <= 32'h0000_0000;
         word_reg <= 32'h0000_0000;
         tog_reg <= 1'b0;
         enabled_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         sh_reg <= sh_full; // R3
         if (bit_cnt_reg == `SPG_LAST_BIT) begin
            word_reg <= sh_full; // R26
            if (enabled_reg) begin
               tog_reg <= ~tog_reg; // R2
            end
            if (is_enable) begin
               enabled_reg <= 1'b1; // R2
            end
         end
      end
   end

   // level crossing: busy shows reads of flash and eeprom as FF
   always_ff @(posedge prog_sck or posedge link_rst) begin
      if (link_rst) begin
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
      end else begin
         busy_s1_reg <= busy_reg;
         busy_s2_reg <= busy_s1_reg;
      end
   end

   // read path looks at arrays that only change while busy
   assign lb1 = sh_reg[23:16];
   assign lb2 = sh_reg[15:8];
   assign lb3 = sh_reg[7:0];
   assign rd_waddr = {lb2[6:0], lb3};
   assign rd_eaddr = {lb2[2:0], lb3};
   assign rd_word = flash_mem[rd_waddr];
   assign rd_flash = (lb1 & `SPG_H_MASK) == `SPG_RD_PROG;
   assign rd_eep = lb1 == `SPG_RD_EEP;
   assign rd_fhi = lb1 == `SPG_RD_LOCK && lb2 == `SPG_RD_FHI_B2;
   assign rd_lock = lb1 == `SPG_RD_LOCK && lb2 != `SPG_RD_FHI_B2;
   assign rd_flo = lb1 == `SPG_RD_FUSE;
   assign rd_mem_byte = rd_flash ? (lb1[`SPG_H_BIT] ? rd_word[15:8]
                                                    : rd_word[7:0])
      : rd_eep ? eep_mem[rd_eaddr]
      : rd_lock ? lock_reg
      : rd_fhi ? fuse_hi_reg
      : rd_flo ? fuse_lo_reg
      : lb3;
   assign rd_byte = (busy_s2_reg && (rd_flash || rd_eep) && enabled_reg)
      ? `SPG_ERASED8 : rd_mem_byte; // R21

   always_ff @(negedge prog_sck or posedge link_rst) begin
      if (link_rst) begin
         out_sh_reg <= 8'h00;
      end else if (bit_cnt_reg == `SPG_BYTE2_AT) begin
         out_sh_reg <= sh_reg[7:0]; // R9
      end else if (bit_cnt_reg == `SPG_BYTE3_AT) begin
         out_sh_reg <= enabled_reg ? rd_byte : sh_reg[7:0]; // R19
      end else begin
         out_sh_reg <= {out_sh_reg[6:0], 1'b0}; // R4
      end
   end

   assign prog_serial_out = out_sh_reg[7]; // R22 R4

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers on core_clk
   wire [2:0] pin_raw;
   wire [2:0] pin_idle;
   wire [2:0] pin_st;
   assign pin_raw = {program_entry_pin_n, prog_reset_n, prog_sck};
   assign pin_idle = `SPG_PIN_IDLE;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pin
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic st_reg;
         always_ff @(posedge core_clk) begin
            if (!resetn) begin
               s1_reg <= pin_idle[g];
               s2_reg <= pin_idle[g];
               s3_reg <= pin_idle[g];
               st_reg <= pin_idle[g];
            end else begin
               s1_reg <= pin_raw[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  st_reg <= s3_reg;
               end
            end
         end
         assign pin_st[g] = st_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // entry mode
   logic [2:0] cap_cnt_reg;
   logic pen_done_reg;
   wire mode_next;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cap_cnt_reg <= 3'h0;
         pen_done_reg <= 1'b0;
         pen_mode_reg <= 1'b0;
      end else if (cap_cnt_reg != `SPG_PEN_CAP) begin
         cap_cnt_reg <= cap_cnt_reg + 3'h1;
      end else if (!pen_done_reg) begin
         // only the value just after power-on counts
         pen_done_reg <= 1'b1;
         pen_mode_reg <= ~pin_st[`SPG_PIN_PEN]
            & ~pin_st[`SPG_PIN_SCK]; // R7
      end
   end

   assign mode_next = pen_mode_reg | ~pin_st[`SPG_PIN_RST]; // R1 R20

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mode_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         mode_reg <= mode_next;
         oe_n_reg <= ~mode_next; // R22
      end
   end

   ////////////////////////////////////////////////////////////////////
   // instruction event crossing
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_s3_reg;
   logic tog_seen_reg;
   spg_pkg::spg_state_t state_reg;
   logic [`SPG_TMR_W-1:0] tmr_reg;
   logic [14:0] idx_reg;
   logic [7:0] page_reg;
   wire tog_new;
   wire cmd_evt;
   spg_pkg::spg_instr_t cmd;
   wire do_erase;
   wire do_lock;
   wire do_fuse_lo;
   wire do_fuse_hi;
   wire do_load;
   wire do_wpage;
   wire do_weep;
   wire [`SPG_TMR_W-1:0] tmr_dec;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
         tog_seen_reg <= 1'b0;
      end else begin
         tog_s1_reg <= tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
         if (tog_s2_reg == tog_s3_reg) begin
            tog_seen_reg <= tog_s3_reg;
         end
      end
   end

   // word_reg holds still for 32 clocks after its toggle
   assign tog_new = tog_s2_reg == tog_s3_reg && tog_s3_reg != tog_seen_reg;
   // a command arriving while busy is dropped
   assign cmd_evt = tog_new && mode_reg
      && state_reg == spg_pkg::SPG_IDLE; // R2 R21
   assign cmd = word_reg;
   assign do_erase = cmd_evt && cmd.b1 == `SPG_OP_MISC
      && cmd.b2[7:5] == `SPG_ER_TOP; // R25
   assign do_lock = cmd_evt && cmd.b1 == `SPG_OP_MISC
      && cmd.b2[7:5] == `SPG_LOCK_TOP;
   assign do_fuse_lo = cmd_evt && cmd.b1 == `SPG_OP_MISC
      && cmd.b2 == `SPG_FUSE_LO;
   assign do_fuse_hi = cmd_evt && cmd.b1 == `SPG_OP_MISC
      && cmd.b2 == `SPG_FUSE_HI;
   assign do_load = cmd_evt
      && (cmd.b1 & `SPG_H_MASK) == `SPG_LOAD_PG; // R12
   assign do_wpage = cmd_evt && cmd.b1 == `SPG_WRITE_PG; // R14
   assign do_weep = cmd_evt && cmd.b1 == `SPG_WR_EEP; // R16
   assign tmr_dec = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;

   ////////////////////////////////////////////////////////////////////
   // self-timed engine
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_reg <= spg_pkg::SPG_IDLE;
         tmr_reg <= '0;
         idx_reg <= 15'h0000;
         page_reg <= 8'h00;
      end else begin
         case (state_reg)
            spg_pkg::SPG_IDLE: begin
               idx_reg <= 15'h0000;
               if (do_erase) begin
                  state_reg <= spg_pkg::SPG_ERASE; // R18
                  tmr_reg <= `SPG_TMR_W'(ERASE_WAIT_CYC - 1);
               end else if (do_wpage) begin
                  state_reg <= spg_pkg::SPG_PAGE; // R14
                  page_reg <= {cmd.b2[6:0], cmd.b3[7]};
                  tmr_reg <= `SPG_TMR_W'(FLASH_WAIT_CYC - 1); // R23
               end else if (do_weep) begin
                  state_reg <= spg_pkg::SPG_WAIT; // R16
                  tmr_reg <= `SPG_TMR_W'(EEP_WAIT_CYC - 1); // R23
               end else if (do_lock || do_fuse_lo || do_fuse_hi) begin
                  state_reg <= spg_pkg::SPG_WAIT;
                  tmr_reg <= `SPG_TMR_W'(FLASH_WAIT_CYC - 1);
               end
            end
            spg_pkg::SPG_ERASE: begin
               idx_reg <= idx_reg + 15'h0001;
               tmr_reg <= tmr_dec;
               if (idx_reg == 15'(`SPG_FLASH_WORDS - 1)) begin
                  state_reg <= spg_pkg::SPG_WAIT;
               end
            end
            spg_pkg::SPG_PAGE: begin
               idx_reg <= idx_reg + 15'h0001;
               tmr_reg <= tmr_dec;
               if (idx_reg == 15'(`SPG_PAGE_WORDS - 1)) begin
                  state_reg <= spg_pkg::SPG_WAIT;
               end
            end
            default: begin
               tmr_reg <= tmr_dec;
               if (tmr_reg == '0) begin
                  state_reg <= spg_pkg::SPG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= state_reg != spg_pkg::SPG_IDLE
            || do_erase || do_wpage || do_weep
            || do_lock || do_fuse_lo || do_fuse_hi;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // array writes, no reset so they map onto memories
   always_ff @(posedge core_clk) begin
      if (state_reg == spg_pkg::SPG_ERASE) begin
         flash_mem[idx_reg] <= `SPG_ERASED16; // R18
         eep_mem[idx_reg[10:0]] <= `SPG_ERASED8; // R18
      end
      if (state_reg == spg_pkg::SPG_PAGE) begin
         flash_mem[{page_reg, idx_reg[6:0]}]
            <= pbuf_mem[idx_reg[6:0]]; // R14
      end
      if (do_load && cmd.b1[`SPG_H_BIT]) begin
         pbuf_mem[cmd.b3[6:0]][15:8] <= cmd.b4; // R12 R13
      end
      if (do_load && !cmd.b1[`SPG_H_BIT]) begin
         pbuf_mem[cmd.b3[6:0]][7:0] <= cmd.b4; // R12
      end
      if (do_weep) begin
         // overwrite is the erase-then-write of one byte
         eep_mem[{cmd.b2[2:0], cmd.b3}] <= cmd.b4; // R16
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lock_reg <= `SPG_FUSE_RST;
         fuse_lo_reg <= `SPG_FUSE_RST;
         fuse_hi_reg <= `SPG_FUSE_RST;
      end else begin
         if (do_erase) begin
            lock_reg <= `SPG_ERASED8; // R18
         end else if (do_lock) begin
            lock_reg <= {`SPG_LOCK_FIX, cmd.b4[5:0]};
         end
         if (do_fuse_lo) begin
            fuse_lo_reg <= cmd.b4;
         end
         if (do_fuse_hi) begin
            fuse_hi_reg <= cmd.b4;
         end
      end
   end

   assign prog_serial_out_oe_n = oe_n_reg;
   assign prog_mode = mode_reg;
   assign prog_busy = busy_reg;
   assign clock_source_fuses = fuse_lo_reg[3:0];

endmodule : spg_prog_port

// file: testbench/spg_prog_model.sv
// behavioural programmer acting as master of the serial link
`timescale 1ns/1ps
module spg_prog_model (
   output logic prog_sck,
   output logic prog_serial_in,
   input wire logic prog_serial_out
);
   int half_ns = 24;
   initial begin
      prog_sck = 1'b0;
      prog_serial_in = 1'b0;
   end
   // clock idles low outside frames; data inverted once released
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      rx = '0;
      #7;
      for (int i = 31; i >= 0; i--) begin
         prog_serial_in = tx[i];
         #(half_ns);
         prog_sck = 1'b1;
         rx[i] = prog_serial_out;
         #(half_ns);
         prog_sck = 1'b0;
      end
      #(half_ns);
      prog_serial_in = ~prog_serial_in;
   endtask : xfer
endmodule : spg_prog_model

// file: testbench/spg_prog_port_monitor.sv
// assertion checker for the serial programming port
`timescale 1ns/1ps
module spg_prog_port_monitor #(
   parameter int FLASH_WAIT_CYC = 112500,
   parameter int EEP_WAIT_CYC = 225000,
   parameter int ERASE_WAIT_CYC = 225000
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic prog_sck,
   input wire logic prog_reset_n,
   input wire logic program_entry_pin_n,
   input wire logic prog_serial_in,
   input wire logic prog_serial_out,
   input wire logic prog_serial_out_oe_n,
   input wire logic prog_mode,
   input wire logic prog_busy,
   input wire logic [3:0] clock_source_fuses
);
   // erase sweeps the whole flash even when its timer is shorter
   localparam int M1 = ERASE_WAIT_CYC > 32768 ? ERASE_WAIT_CYC : 32768;
   localparam int M2 = FLASH_WAIT_CYC > EEP_WAIT_CYC ? FLASH_WAIT_CYC
      : EEP_WAIT_CYC;
   localparam int BUSY_MAX = (M1 > M2 ? M1 : M2) + 16;
   logic [17:0] busy_cnt_reg;
   logic out_at_rise_reg;
   always_ff @(posedge core_clk) begin
      busy_cnt_reg <= (!resetn || !prog_busy) ? '0 : busy_cnt_reg + 18'h1;
   end
   always_ff @(posedge prog_sck) begin
      out_at_rise_reg <= prog_serial_out;
   end
   a_reset_clean: assert property (
      @(posedge core_clk) disable iff (!resetn) $rose(resetn) |->
      !prog_mode && prog_serial_out_oe_n && !prog_busy
      && clock_source_fuses == 4'hF) else $error("outputs not idle");
   a_mode_entry: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $fell(prog_reset_n) |-> ##[1:8] prog_mode)
      else $error("mode not entered");
   a_mode_exit: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (prog_reset_n && program_entry_pin_n) [*8] |-> !prog_mode)
      else $error("mode not left");
   a_oe_in_mode: assert property (
      @(posedge core_clk) disable iff (!resetn)
      prog_mode [*2] |-> !prog_serial_out_oe_n) else $error("out idle");
   a_oe_off_mode: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !prog_mode [*2] |-> prog_serial_out_oe_n) else $error("out driven");
   a_busy_in_mode: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $rose(prog_busy) |-> prog_mode) else $error("busy outside mode");
   a_busy_min: assert property (
      @(posedge core_clk) disable iff (!resetn)
      $rose(prog_busy) |-> prog_busy [*8]) else $error("busy too short");
   a_busy_bound: assert property (
      @(posedge core_clk) disable iff (!resetn)
      int'(busy_cnt_reg) <= BUSY_MAX) else $error("busy too long");
   a_fuse_quiet: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !prog_mode && !prog_busy |=> $stable(clock_source_fuses))
      else $error("fuses moved outside mode");
   a_out_on_fall: assert property (
      @(negedge prog_sck) disable iff (!resetn)
      prog_serial_out == out_at_rise_reg) else $error("out moved on rise");
endmodule : spg_prog_port_monitor

// file: testbench/spg_prog_port_tb_top.sv
// testbench for the serial programming port
`timescale 1ns/1ps
module spg_prog_port_tb_top;
   localparam int WAIT_CYC = 200;
   logic core_clk;
   logic resetn;
   logic prog_reset_n;
   logic program_entry_pin_n;
   logic prog_sck;
   logic prog_serial_in;
   logic prog_serial_out;
   logic prog_serial_out_oe_n;
   logic prog_mode;
   logic prog_busy;
   logic [3:0] clock_source_fuses;
   logic [31:0] rx;
   int failures = 0;
   int n_tests = 0;
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   spg_prog_port #(.FLASH_WAIT_CYC(WAIT_CYC), .EEP_WAIT_CYC(WAIT_CYC),
      .ERASE_WAIT_CYC(WAIT_CYC)) DUT (.core_clk(core_clk), .resetn(resetn),
      .prog_sck(prog_sck), .prog_reset_n(prog_reset_n),
      .program_entry_pin_n(program_entry_pin_n),
      .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
      .prog_serial_out_oe_n(prog_serial_out_oe_n), .prog_mode(prog_mode),
      .prog_busy(prog_busy), .clock_source_fuses(clock_source_fuses));
   spg_prog_model u_prog (.prog_sck(prog_sck),
      .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input logic [31:0] tx);
      u_prog.xfer(tx, rx);
      repeat (8) @(posedge core_clk);
   endtask : send
   task automatic wait_idle;
      int n;
      n = 0;
      while (prog_busy !== 1'b0 && n < 40000) begin
         @(posedge core_clk);
         n++;
      end
      check({7'h0, n < 40000}, 8'h01);
   endtask : wait_idle
   task automatic stop_test;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic t_locked;
      prog_reset_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      check({7'h0, prog_mode}, 8'h01);
      send(32'hC0_00_05_5A);
      check({7'h0, prog_busy}, 8'h00);
      send(32'hA0_00_05_00);
      check(rx[7:0], 8'h05);
   endtask : t_locked
   task automatic t_enable;
      send(32'hAC_53_00_00);
      check(rx[15:8], 8'h53);
      check({7'h0, prog_serial_out_oe_n}, 8'h00);
      // a reset pulse drops sync, so enable must come again
      prog_reset_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      prog_reset_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      send(32'hA0_00_05_00);
      check(rx[7:0], 8'h05);
      send(32'hAC_53_00_00);
      check(rx[15:8], 8'h53);
   endtask : t_enable
   task automatic t_erase;
      send(32'hAC_80_00_00);
      check({7'h0, prog_busy}, 8'h01);
      send(32'h20_00_00_00);
      check(rx[7:0], 8'hFF);
      wait_idle;
      send(32'h28_7F_FF_00);
      check(rx[7:0], 8'hFF);
      send(32'hA0_07_FF_00);
      check(rx[7:0], 8'hFF);
   endtask : t_erase
   task automatic t_page;
      send(32'h40_00_00_11);
      send(32'h48_00_00_22);
      send(32'h40_00_7F_33);
      send(32'h48_00_7F_44);
      send(32'h4C_01_00_00);
      check({7'h0, prog_busy}, 8'h01);
      wait_idle;
      send(32'h20_01_00_00);
      check(rx[7:0], 8'h11);
      send(32'h28_01_00_00);
      check(rx[7:0], 8'h22);
      send(32'h28_01_7F_00);
      check(rx[7:0], 8'h44);
      send(32'h20_01_7F_00);
      check(rx[7:0], 8'h33);
      send(32'h20_00_00_00);
      check(rx[7:0], 8'hFF);
   endtask : t_page
   task automatic t_eeprom;
      send(32'hC0_07_FF_5A);
      // second write lands while busy and must be dropped
      send(32'hC0_07_FF_00);
      send(32'hA0_07_FF_00);
      check(rx[7:0], 8'hFF);
      wait_idle;
      send(32'hA0_07_FF_00);
      check(rx[7:0], 8'h5A);
      send(32'hC0_07_FF_33);
      wait_idle;
      send(32'hA0_07_FF_00);
      check(rx[7:0], 8'h33);
   endtask : t_eeprom
   task automatic t_fuse;
      // three core cycles per clock phase at this core rate
      u_prog.half_ns = 120;
      send(32'hAC_A0_00_F3);
      wait_idle;
      check({4'h0, clock_source_fuses}, 8'h03);
      send(32'hAC_A8_00_D9);
      wait_idle;
      send(32'hAC_E0_00_C5);
      wait_idle;
      send(32'h50_00_00_00);
      check(rx[7:0], 8'hF3);
      send(32'h58_08_00_00);
      check(rx[7:0], 8'hD9);
      send(32'h58_00_00_00);
      check(rx[7:0], 8'hC5);
      u_prog.half_ns = 24;
   endtask : t_fuse
   task automatic t_exit;
      prog_reset_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      check({6'h0, prog_mode, prog_serial_out_oe_n}, 8'h01);
   endtask : t_exit
   task automatic t_entry;
      resetn <= 1'b0;
      program_entry_pin_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (20) @(posedge core_clk);
      check({3'h0, prog_mode, clock_source_fuses}, 8'h1F);
      send(32'hAC_53_00_00);
      check(rx[15:8], 8'h53);
      resetn <= 1'b0;
      program_entry_pin_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (20) @(posedge core_clk);
      check({7'h0, prog_mode}, 8'h00);
   endtask : t_entry
   initial begin
      resetn = 1'b0;
      prog_reset_n = 1'b1;
      program_entry_pin_n = 1'b1;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (10) @(posedge core_clk);
      check({prog_mode, prog_busy, prog_serial_out_oe_n, 1'b0,
         clock_source_fuses}, 8'h2F);
      t_locked;
      t_enable;
      t_erase;
      t_page;
      t_eeprom;
      t_fuse;
      t_exit;
      t_entry;
      stop_test;
   end
   // erase sweep dominates the run, about 33k cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      failures++;
      stop_test;
   end
endmodule : spg_prog_port_tb_top
bind spg_prog_port spg_prog_port_monitor #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC),
   .EEP_WAIT_CYC(EEP_WAIT_CYC), .ERASE_WAIT_CYC(ERASE_WAIT_CYC)) u_mon (
   .core_clk(core_clk), .resetn(resetn), .prog_sck(prog_sck),
   .prog_reset_n(prog_reset_n), .program_entry_pin_n(program_entry_pin_n),
   .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
   .prog_serial_out_oe_n(prog_serial_out_oe_n), .prog_mode(prog_mode),
   .prog_busy(prog_busy), .clock_source_fuses(clock_source_fuses));
